// *** rws_far_model.sv ***
// ----------------------------------------------------------------
// Far side: reset pin, watchdog and port pins
// ----------------------------------------------------------------
module rws_far_model (
   input wire logic clk,
   output logic reset_pin_n,
   output logic wdt_pulse,
   output logic [rws_pkg::PORT_W-1:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pin idles high, as its pull-up would hold it
   initial begin
      reset_pin_n = 1'b1;
      wdt_pulse = 1'b0;
      pins = 8'h00;
   end
   // One-cycle time-out, changed only after an edge
   task automatic fire_wdt();
      @(posedge clk);
      wdt_pulse <= 1'b1;
      @(posedge clk);
      wdt_pulse <= 1'b0;
   endtask : fire_wdt
   // Pin held low for n cycles
   task automatic press(input int n);
      reset_pin_n <= 1'b0;
      repeat (n) @(posedge clk);
      reset_pin_n <= 1'b1;
   endtask : press
   // Every pin flips, so each differs from the last read
   task automatic move_pins();
      pins <= ~pins;
   endtask : move_pins
endmodule : rws_far_model

// *** rws_pkg.sv ***
package rws_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam logic [6:0] IDX_STATUS = 7'h03;
   localparam logic [6:0] IDX_RES_HI = 7'h0C;
   localparam logic [6:0] IDX_RES_LO = 7'h0D;
   localparam logic [6:0] IDX_CONV_FLAGS = 7'h0E;
   localparam logic [6:0] IDX_TMR_FLAGS = 7'h0F;
   localparam logic [6:0] IDX_RAM_FIRST = 7'h10;
   localparam logic [6:0] IDX_RAM_LAST = 7'h3F;
   localparam logic [6:0] IDX_IRQ_STAT = 7'h40;
   localparam logic [6:0] IDX_IRQ_MASK = 7'h41;
   localparam logic [6:0] IDX_UNMAPPED = 7'h7F;

   // ----------------------------------------------------------------
   // Field positions and masks
   // ----------------------------------------------------------------
   localparam int CF_CONV_DONE = 5;
   localparam int CF_CMP_CHG = 4;
   localparam int CF_CONV_WE = 3;
   localparam int CF_CMP_WE = 2;
   localparam int CF_PORT_WE = 1;
   localparam logic [7:0] CF_WMASK = 8'h3E;
   localparam int TF_LOW_PW = 7;
   localparam int TF_HIGH_PW = 6;
   localparam int TF_TMR_C = 5;
   localparam int TF_TMR_B = 4;
   localparam int TF_TMR_A = 3;
   localparam int TF_EXT = 2;
   localparam int TF_PORT = 1;
   localparam int TF_MAIN = 0;
   localparam logic [7:0] TF_WMASK = 8'hFF;
   localparam int ST_RST_BIT = 6;
   localparam int ST_T_BIT = 4;
   localparam int ST_P_BIT = 3;
   localparam int IE_PIN_RST = 0;
   localparam int IE_WDT_RST = 1;
   localparam int IE_WAKE = 2;
   localparam int IE_PORT_CHG = 3;
   localparam int IRQ_W = 4;

   // ----------------------------------------------------------------
   // Sizes, vector, reset values
   // ----------------------------------------------------------------
   localparam int PORT_W = 8;
   localparam int RAM_DEPTH = 48;
   localparam logic [11:0] VEC_PORT_CHANGE = 12'h006;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic rst_flag;
      logic t_flag;
      logic p_flag;
   } rws_cause_t;

   typedef struct packed {
      logic main_ovf;
      logic tmr_a_ovf;
      logic tmr_b_ovf;
      logic tmr_c_ovf;
      logic ext_pin;
      logic conv_done;
      logic cmp_change;
      logic high_pw_unf;
      logic low_pw_unf;
   } rws_src_t;

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_SLEEP = 3'b010,
      ST_RESET = 3'b100
   } rws_state_t;

   localparam rws_cause_t CAUSE_POR = '{1'b0, 1'b1, 1'b1};
   localparam rws_cause_t CAUSE_PIN_WAKE = '{1'b0, 1'b1, 1'b0};
   localparam rws_cause_t CAUSE_WDT_RUN = '{1'b0, 1'b0, 1'b1};
   localparam rws_cause_t CAUSE_WDT_WAKE = '{1'b0, 1'b0, 1'b0};
   localparam rws_cause_t CAUSE_CHG_WAKE = '{1'b1, 1'b1, 1'b0};

endpackage : rws_pkg

// *** rws_port_change.sv ***
// ------------------------------------------------------------------
// Port input-change detector
// ------------------------------------------------------------------
module rws_port_change (
   input wire logic clk,
   input wire logic rst,
   input wire logic [rws_pkg::PORT_W-1:0] pins_async,
   input wire logic port_read,
   output logic change
);
   logic [rws_pkg::PORT_W-1:0] pins_sync;
   logic [rws_pkg::PORT_W-1:0] ref_reg;
   logic [rws_pkg::PORT_W-1:0] ref_next;
   logic [rws_pkg::PORT_W-1:0] diff;

   rws_sync #(.W(rws_pkg::PORT_W)) u_pin_sync (
      .clk(clk),
      .rst(rst),
      .d_async(pins_async),
      .q_sync(pins_sync)
   );

   // Reference is refreshed only by a port read
   always_comb begin
      ref_next = port_read ? pins_sync : ref_reg;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ref_reg <= '0;
      end else begin
         ref_reg <= ref_next;
      end
   end

   // Every pin compares against its own reference
   for (genvar i = 0; i < rws_pkg::PORT_W; i++) begin : g_pin
      assign diff[i] = pins_sync[i] ^ ref_reg[i]; // R11
   end

   assign change = |diff;
endmodule : rws_port_change

// *** rws_sync.sv ***
// ------------------------------------------------------------------
// Two-stage level synchroniser
// ------------------------------------------------------------------
module rws_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d_async,
   output logic [W-1:0] q_sync
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   // First stage feeds only the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= d_async;
         sync_reg <= meta_reg;
      end
   end

   assign q_sync = sync_reg;
endmodule : rws_sync

// *** rws_top.sv ***
// Contract
// R01: Reset comes from power-on, reset pin low, or enabled watchdog time-out.
// R02: Power-on gives wake flag 0, time-out flag 1, power-down flag 1.
// R03: Reset pin while running clears wake flag, keeps time-out and power-down.
// R04: Reset pin wake from sleep gives flags 0, 1, 0.
// R05: Watchdog reset while running gives flags 0, 0, 1.
// R06: Watchdog wake from sleep clears all three flags.
// R07: Port-change wake from sleep gives flags 1, 1, 0.
// R08: Clear sets time-out and power-down; sleep sets time-out, clears power-down.
// R09: Six interrupt source groups are recorded.
// R10: Software reads the port before enabling the change interrupt.
// R11: Any port pin differing from its last-read level raises change.
// R12: Change wakes only if its enable was set before sleeping.
// R13: After change wake, resume in line or branch to 006H if enabled.
// R14: Flags and wake enables clear on resets, keep on change wake.
// R15: Result high upper nibble reads 0; storage keeps contents over resets.
// R16: Flags except port-change set regardless of global interrupt enable.
// R17: The three cause flags read as separate status register bits.
module rws_top (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic RESET_PIN_N,
   input wire logic WATCHDOG_TIMEOUT,
   input wire logic WATCHDOG_ENABLE,
   input wire logic WATCHDOG_CLEAR_INSTR,
   input wire logic SLEEP_INSTR,
   input wire logic GLOBAL_INT_EN,
   input wire logic PORT_READ,
   input wire logic [rws_pkg::PORT_W-1:0] PORT_PINS,
   input wire rws_pkg::rws_src_t SRC_EVENTS,
   input wire logic [11:0] CONV_DATA,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic CPU_RESET,
   output logic SLEEPING,
   output logic WAKE_RESUME,
   output logic VECTOR_BRANCH,
   output logic [11:0] VECTOR_ADDR,
   output rws_pkg::rws_cause_t CAUSE,
   output logic IRQ
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   rws_pkg::rws_state_t state_reg, state_next;
   rws_pkg::rws_cause_t cause_reg, cause_next;
   logic port_change_wake_enable_sl_reg, port_change_wake_enable_sl_next, resume_reg, resume_next, branch_reg, branch_next;
   logic [11:0] vec_reg, vec_next;
   logic [7:0] cf_reg, cf_next, tf_reg, tf_next, rd_val, res_lo_reg;
   logic [rws_pkg::IRQ_W-1:0] ist_reg, ist_next, imk_reg, imk_next, iev;
   logic irq_reg, irq_next, rd_pend_reg, rd_pend_next, wr_pend_reg, wr_pend_next;
   logic [6:0] idx_reg, idx_next, a_idx, ram_ofs;
   logic hready_reg, hready_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic accept, pin_low, port_chg, wdt_hit, ev_pin, ev_wdt, ev_wake;
   logic [3:0] res_hi_reg;
   logic [7:0] ram_reg [rws_pkg::RAM_DEPTH];
   // Mapped general-purpose storage window
   function automatic logic is_ram(input logic [6:0] idx);
      is_ram = (idx >= rws_pkg::IDX_RAM_FIRST) && (idx <= rws_pkg::IDX_RAM_LAST);
   endfunction : is_ram
   // ----------------------------------------------------------------
   // Pin side
   // ----------------------------------------------------------------
   // Inverted before syncing so the sync resets to "pin inactive"
   rws_sync #(.W(1)) u_rst_sync (
      .clk(CLK),
      .rst(SYS_RST),
      .d_async(~RESET_PIN_N),
      .q_sync(pin_low)
   );
   rws_port_change u_port (
      .clk(CLK),
      .rst(SYS_RST),
      .pins_async(PORT_PINS),
      .port_read(PORT_READ), // R10
      .change(port_chg)
   );
   assign wdt_hit = WATCHDOG_TIMEOUT & WATCHDOG_ENABLE; // R01
   // ----------------------------------------------------------------
   // Run / sleep / reset sequencer and cause flags
   // ----------------------------------------------------------------
   // Pin reset outranks watchdog, which outranks instructions
   always_comb begin
      state_next = state_reg;
      cause_next = cause_reg;
      port_change_wake_enable_sl_next = port_change_wake_enable_sl_reg;
      resume_next = 1'b0;
      branch_next = 1'b0;
      vec_next = vec_reg;
      ev_pin = 1'b0;
      ev_wdt = 1'b0;
      ev_wake = 1'b0;
      case (state_reg)
         rws_pkg::ST_RUN: begin
            if (pin_low) begin
               state_next = rws_pkg::ST_RESET; // R01
               cause_next.rst_flag = 1'b0; // R03
               ev_pin = 1'b1;
            end else if (wdt_hit) begin
               state_next = rws_pkg::ST_RESET; // R01
               cause_next = rws_pkg::CAUSE_WDT_RUN; // R05
               ev_wdt = 1'b1;
            end else if (SLEEP_INSTR) begin
               state_next = rws_pkg::ST_SLEEP;
               cause_next.t_flag = 1'b1; // R08
               cause_next.p_flag = 1'b0; // R08
               port_change_wake_enable_sl_next = cf_reg[rws_pkg::CF_PORT_WE]; // R12
            end else if (WATCHDOG_CLEAR_INSTR) begin
               cause_next.t_flag = 1'b1; // R08
               cause_next.p_flag = 1'b1; // R08
            end
         end
         rws_pkg::ST_SLEEP: begin
            if (pin_low) begin
               state_next = rws_pkg::ST_RESET;
               cause_next = rws_pkg::CAUSE_PIN_WAKE; // R04
               ev_pin = 1'b1;
               ev_wake = 1'b1;
            end else if (wdt_hit) begin
               state_next = rws_pkg::ST_RESET;
               cause_next = rws_pkg::CAUSE_WDT_WAKE; // R06
               ev_wdt = 1'b1;
               ev_wake = 1'b1;
            end else if (port_chg && port_change_wake_enable_sl_reg) begin // R12
               state_next = rws_pkg::ST_RUN;
               cause_next = rws_pkg::CAUSE_CHG_WAKE; // R07
               ev_wake = 1'b1;
               if (GLOBAL_INT_EN) begin
                  branch_next = 1'b1; // R13
                  vec_next = rws_pkg::VEC_PORT_CHANGE; // R13
               end else begin
                  resume_next = 1'b1; // R13
               end
            end
         end
         rws_pkg::ST_RESET: begin
            // Held for as long as the pin stays low
            if (!pin_low) state_next = rws_pkg::ST_RUN;
         end
         default: state_next = rws_pkg::ST_RUN;
      endcase
   end
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_reg <= rws_pkg::ST_RUN;
         cause_reg <= rws_pkg::CAUSE_POR; // R02
         port_change_wake_enable_sl_reg <= 1'b0;
         resume_reg <= 1'b0;
         branch_reg <= 1'b0;
         vec_reg <= 12'h000;
      end else begin
         state_reg <= state_next;
         cause_reg <= cause_next;
         port_change_wake_enable_sl_reg <= port_change_wake_enable_sl_next;
         resume_reg <= resume_next;
         branch_reg <= branch_next;
         vec_reg <= vec_next;
      end
   end
   // ----------------------------------------------------------------
   // Interrupt source flags and wake enables
   // ----------------------------------------------------------------
   // Hardware set is applied after the software write, so it wins
   always_comb begin
      cf_next = cf_reg;
      tf_next = tf_reg;
      if (wr_pend_reg && idx_reg == rws_pkg::IDX_CONV_FLAGS) begin
         cf_next = HWDATA[7:0] & rws_pkg::CF_WMASK;
      end
      if (wr_pend_reg && idx_reg == rws_pkg::IDX_TMR_FLAGS) begin
         tf_next = HWDATA[7:0] & rws_pkg::TF_WMASK;
      end
      cf_next[rws_pkg::CF_CONV_DONE] |= SRC_EVENTS.conv_done; // R16
      cf_next[rws_pkg::CF_CMP_CHG] |= SRC_EVENTS.cmp_change; // R16
      tf_next[rws_pkg::TF_MAIN] |= SRC_EVENTS.main_ovf; // R09
      tf_next[rws_pkg::TF_TMR_A] |= SRC_EVENTS.tmr_a_ovf; // R09
      tf_next[rws_pkg::TF_TMR_B] |= SRC_EVENTS.tmr_b_ovf; // R09
      tf_next[rws_pkg::TF_TMR_C] |= SRC_EVENTS.tmr_c_ovf; // R09
      tf_next[rws_pkg::TF_EXT] |= SRC_EVENTS.ext_pin; // R16
      tf_next[rws_pkg::TF_HIGH_PW] |= SRC_EVENTS.high_pw_unf; // R16
      tf_next[rws_pkg::TF_LOW_PW] |= SRC_EVENTS.low_pw_unf; // R16
      // Port-change flag alone needs its enable
      tf_next[rws_pkg::TF_PORT] |= port_chg & cf_reg[rws_pkg::CF_PORT_WE];
      if (state_reg == rws_pkg::ST_RESET) begin
         cf_next = rws_pkg::FLAGS_RESET; // R14
         tf_next = rws_pkg::FLAGS_RESET; // R14
      end
   end
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         cf_reg <= rws_pkg::FLAGS_RESET; // R14
         tf_reg <= rws_pkg::FLAGS_RESET; // R14
      end else begin
         cf_reg <= cf_next;
         tf_reg <= tf_next;
      end
   end
   // ----------------------------------------------------------------
   // Conversion result and general-purpose storage
   // ----------------------------------------------------------------
   // No reset here: contents survive every restart, unknown at power-on
   assign ram_ofs = idx_reg - rws_pkg::IDX_RAM_FIRST;
   always_ff @(posedge CLK) begin
      if (SRC_EVENTS.conv_done) begin
         res_hi_reg <= CONV_DATA[11:8];
         res_lo_reg <= CONV_DATA[7:0];
      end
      if (wr_pend_reg && is_ram(idx_reg)) begin
         ram_reg[ram_ofs[5:0]] <= HWDATA[7:0]; // R15
      end
   end
   // ----------------------------------------------------------------
   // Event status, mask and interrupt line
   // ----------------------------------------------------------------
   always_comb begin
      iev = '0;
      iev[rws_pkg::IE_PIN_RST] = ev_pin;
      iev[rws_pkg::IE_WDT_RST] = ev_wdt;
      iev[rws_pkg::IE_WAKE] = ev_wake;
      iev[rws_pkg::IE_PORT_CHG] = port_chg & cf_reg[rws_pkg::CF_PORT_WE]
                                  & ~tf_reg[rws_pkg::TF_PORT];
      ist_next = ist_reg;
      // Read-clear first, so a same-cycle event still lands
      if (rd_pend_reg && idx_reg == rws_pkg::IDX_IRQ_STAT) ist_next = '0;
      ist_next = ist_next | iev;
      imk_next = imk_reg;
      if (wr_pend_reg && idx_reg == rws_pkg::IDX_IRQ_MASK) imk_next = HWDATA[rws_pkg::IRQ_W-1:0];
      irq_next = |(ist_next & imk_next);
   end
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         ist_reg <= rws_pkg::IRQ_RESET;
         imk_reg <= rws_pkg::IRQ_RESET;
         irq_reg <= 1'b0;
      end else begin
         ist_reg <= ist_next;
         imk_reg <= imk_next;
         irq_reg <= irq_next;
      end
   end
   // ----------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------
   // Reads take one wait state so a write just before is visible
   assign accept = HSEL && HTRANS == rws_pkg::HTRANS_NONSEQ && HREADY;
   assign a_idx = (HADDR[31:9] == 23'h000000) ? HADDR[8:2] : rws_pkg::IDX_UNMAPPED;
   always_comb begin
      rd_val = 8'h00;
      case (idx_reg)
         rws_pkg::IDX_STATUS: begin
            rd_val[rws_pkg::ST_RST_BIT] = cause_reg.rst_flag; // R17
            rd_val[rws_pkg::ST_T_BIT] = cause_reg.t_flag; // R17
            rd_val[rws_pkg::ST_P_BIT] = cause_reg.p_flag; // R17
         end
         rws_pkg::IDX_RES_HI: rd_val = {4'h0, res_hi_reg}; // R15
         rws_pkg::IDX_RES_LO: rd_val = res_lo_reg;
         rws_pkg::IDX_CONV_FLAGS: rd_val = cf_reg & rws_pkg::CF_WMASK;
         rws_pkg::IDX_TMR_FLAGS: rd_val = tf_reg;
         rws_pkg::IDX_IRQ_STAT: rd_val = {4'h0, ist_reg};
         rws_pkg::IDX_IRQ_MASK: rd_val = {4'h0, imk_reg};
         default: begin
            if (is_ram(idx_reg)) begin
               rd_val = ram_reg[ram_ofs[5:0]];
            end
         end
      endcase
   end
   always_comb begin
      idx_next = idx_reg;
      wr_pend_next = 1'b0;
      rd_pend_next = 1'b0;
      hready_next = 1'b1;
      hrdata_next = hrdata_reg;
      if (accept) begin
         idx_next = a_idx;
         wr_pend_next = HWRITE;
         rd_pend_next = ~HWRITE;
         hready_next = HWRITE;
      end
      if (rd_pend_reg) begin
         hrdata_next = {24'h000000, rd_val};
      end
   end
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         idx_reg <= rws_pkg::IDX_UNMAPPED;
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         hready_reg <= 1'b1;
         hrdata_reg <= 32'h00000000;
      end else begin
         idx_reg <= idx_next;
         wr_pend_reg <= wr_pend_next;
         rd_pend_reg <= rd_pend_next;
         hready_reg <= hready_next;
         hrdata_reg <= hrdata_next;
      end
   end
   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign HRDATA = hrdata_reg;
   assign HREADYOUT = hready_reg;
   assign HRESP = 1'b0;
   assign CPU_RESET = state_reg[2];
   assign SLEEPING = state_reg[1];
   assign WAKE_RESUME = resume_reg;
   assign VECTOR_BRANCH = branch_reg;
   assign VECTOR_ADDR = vec_reg;
   assign CAUSE = cause_reg;
   assign IRQ = irq_reg;
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   sequence s_sleep_chg;
      state_reg == rws_pkg::ST_SLEEP && !pin_low && !wdt_hit && port_chg && port_change_wake_enable_sl_reg;
   endsequence
   sequence s_run_wdt;
      state_reg == rws_pkg::ST_RUN && !pin_low && wdt_hit;
   endsequence
   a_pin_run_keep: assert property (state_reg == rws_pkg::ST_RUN && pin_low |=> // R03
      CPU_RESET && !CAUSE.rst_flag && CAUSE.t_flag == $past(cause_reg.t_flag)
      && CAUSE.p_flag == $past(cause_reg.p_flag))
      else $error("pin reset in run altered flags");
   a_pin_sleep_wake: assert property (state_reg == rws_pkg::ST_SLEEP && pin_low |=> // R04
      CPU_RESET && CAUSE == rws_pkg::CAUSE_PIN_WAKE)
      else $error("pin wake flags wrong");
   a_wdt_run_pulse: assert property (s_run_wdt ##1 !pin_low |-> // R05
      CAUSE == rws_pkg::CAUSE_WDT_RUN && CPU_RESET ##1 !CPU_RESET)
      else $error("watchdog reset in run wrong");
   a_wdt_sleep_wake: assert property (state_reg == rws_pkg::ST_SLEEP && !pin_low && wdt_hit
      |=> CAUSE == rws_pkg::CAUSE_WDT_WAKE && CPU_RESET) // R06
      else $error("watchdog wake flags wrong");
   a_wdt_disabled: assert property (state_reg == rws_pkg::ST_RUN && !pin_low // R01
      && WATCHDOG_TIMEOUT && !WATCHDOG_ENABLE |=> !CPU_RESET)
      else $error("disabled watchdog caused reset");
   a_chg_wake_flags: assert property (s_sleep_chg |=> // R07
      CAUSE == rws_pkg::CAUSE_CHG_WAKE && !SLEEPING && !CPU_RESET)
      else $error("change wake flags wrong");
   a_chg_wake_vector: assert property (s_sleep_chg |=> // R13
      (VECTOR_BRANCH == $past(GLOBAL_INT_EN)) && (WAKE_RESUME != VECTOR_BRANCH)
      && (!VECTOR_BRANCH || VECTOR_ADDR == rws_pkg::VEC_PORT_CHANGE) ##1
      !VECTOR_BRANCH && !WAKE_RESUME)
      else $error("change wake branch wrong");
   a_no_wake_unarmed: assert property (state_reg == rws_pkg::ST_SLEEP && !port_change_wake_enable_sl_reg // R12
      && !pin_low && !wdt_hit |=> SLEEPING)
      else $error("woke without armed enable");
   a_instr_flags: assert property (state_reg == rws_pkg::ST_RUN && !pin_low && !wdt_hit // R08
      && (SLEEP_INSTR || WATCHDOG_CLEAR_INSTR) |=> CAUSE.t_flag
      && CAUSE.p_flag == !$past(SLEEP_INSTR) && CAUSE.rst_flag == $past(cause_reg.rst_flag))
      else $error("instruction flag update wrong");
   a_reset_clears: assert property (CPU_RESET |=> cf_reg == 8'h00 && tf_reg == 8'h00) // R14
      else $error("flags survived reset");
   a_flag_set_wins: assert property (SRC_EVENTS.conv_done && state_reg != rws_pkg::ST_RESET
      |=> cf_reg[rws_pkg::CF_CONV_DONE]) // R16
      else $error("conversion flag not set");
endmodule : rws_top

// *** tb_reset_wake_status.sv ***
module tb_reset_wake_status;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
      $display("unexpected %s exp %0h got %0h", nm, e, g); end end
   logic CLK = 1'b0, SYS_RST = 1'b1, WATCHDOG_ENABLE = 1'b1, WATCHDOG_CLEAR_INSTR = 1'b0;
   logic SLEEP_INSTR = 1'b0, GLOBAL_INT_EN = 1'b0, PORT_READ = 1'b0, HSEL = 1'b0;
   logic HWRITE = 1'b0, HRESP, CPU_RESET, SLEEPING, WAKE_RESUME, VECTOR_BRANCH, IRQ;
   logic RESET_PIN_N, WATCHDOG_TIMEOUT, HREADYOUT, wr_seen, vb_seen, cr_seen;
   logic [1:0] HTRANS = 2'h0;
   logic [2:0] HSIZE = 3'h2;
   logic [11:0] CONV_DATA = 12'hABC, VECTOR_ADDR;
   logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, q;
   logic [rws_pkg::PORT_W-1:0] PORT_PINS;
   rws_pkg::rws_src_t SRC_EVENTS = '0;
   rws_pkg::rws_cause_t CAUSE;
   int bad_count = 0, n_compared = 0;
   wire HREADY = HREADYOUT;
   rws_far_model rws_far_model_i (.clk(CLK), .reset_pin_n(RESET_PIN_N),
      .wdt_pulse(WATCHDOG_TIMEOUT), .pins(PORT_PINS));
   rws_top rws_top_i (.CLK, .SYS_RST, .RESET_PIN_N, .WATCHDOG_TIMEOUT, .WATCHDOG_ENABLE,
      .WATCHDOG_CLEAR_INSTR, .SLEEP_INSTR, .GLOBAL_INT_EN, .PORT_READ, .PORT_PINS,
      .SRC_EVENTS, .CONV_DATA, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY,
      .HRDATA, .HREADYOUT, .HRESP, .CPU_RESET, .SLEEPING, .WAKE_RESUME, .VECTOR_BRANCH,
      .VECTOR_ADDR, .CAUSE, .IRQ);
   initial begin
      forever #5 CLK = ~CLK;
   end
   // Resume, branch and watchdog reset pulses last one cycle, so they are caught here
   always @(posedge CLK) begin
      if (WAKE_RESUME) wr_seen = 1'b1;
      if (VECTOR_BRANCH) vb_seen = 1'b1;
      if (CPU_RESET) cr_seen = 1'b1;
   end
   task automatic wrap_up();
      if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   // ----------------------------------------------------------------
   // Bus access: address phase, then data phase, each until ready
   // ----------------------------------------------------------------
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      HSEL <= 1'b1;
      HADDR <= a;
      HWRITE <= w;
      HTRANS <= rws_pkg::HTRANS_NONSEQ;
      n = 0;
      do begin @(posedge CLK); n++; end while (HREADYOUT !== 1'b1 && n < 50);
      HTRANS <= 2'h0;
      HWDATA <= d;
      do begin @(posedge CLK); n++; end while (HREADYOUT !== 1'b1 && n < 100);
      q = HRDATA;
      if (n >= 100) begin bad_count++; wrap_up(); end
   endtask : bus
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK("read", e, q)
   endtask : rd
   // One-cycle pulse on {port read, sleep, clear}, then lets the block settle
   task automatic pulse(input logic [2:0] m);
      {PORT_READ, SLEEP_INSTR, WATCHDOG_CLEAR_INSTR} <= m;
      @(posedge CLK);
      {PORT_READ, SLEEP_INSTR, WATCHDOG_CLEAR_INSTR} <= 3'b000;
      repeat (3) @(posedge CLK);
   endtask : pulse
   task automatic arm_and_sleep();
      pulse(3'b100);
      bus(1'b1, 32'h38, 32'h2);
      pulse(3'b010);
      wr_seen = 1'b0;
      vb_seen = 1'b0;
      rws_far_model_i.move_pins();
      repeat (6) @(posedge CLK);
   endtask : arm_and_sleep
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge CLK);
      SYS_RST <= 1'b0;
      @(posedge CLK);
      `CHK("cause", 3'b011, CAUSE)
      rd(32'h0C, 32'h18);
      `CHK("hresp", 1'b0, HRESP)
      rd(32'h1FC, 32'h0);
      rd(32'h100, 32'h0);
      bus(1'b1, 32'h104, 32'h4);
      bus(1'b1, 32'h40, 32'hA5);
      rd(32'h40, 32'hA5);
      SRC_EVENTS <= 9'h1FF;
      @(posedge CLK);
      SRC_EVENTS <= '0;
      rd(32'h30, 32'h0A);
      rd(32'h34, 32'hBC);
      rd(32'h38, 32'h30);
      rd(32'h3C, 32'hFD);
      rws_far_model_i.fire_wdt();
      repeat (4) @(posedge CLK);
      `CHK("cause", 3'b001, CAUSE)
      rd(32'h38, 32'h0);
      rd(32'h40, 32'hA5);
      pulse(3'b001);
      `CHK("cause", 3'b011, CAUSE)
      pulse(3'b010);
      `CHK("cause", 3'b010, CAUSE)
      rws_far_model_i.move_pins();
      repeat (6) @(posedge CLK);
      `CHK("asleep", 1'b1, SLEEPING)
      rws_far_model_i.fire_wdt();
      repeat (4) @(posedge CLK);
      `CHK("cause", 3'b000, CAUSE)
      arm_and_sleep();
      `CHK("cause", 3'b110, CAUSE)
      `CHK("resume", 1'b1, wr_seen)
      `CHK("irq", 1'b1, IRQ)
      rd(32'h38, 32'h2);
      rd(32'h100, 32'hE);
      `CHK("irq", 1'b0, IRQ)
      cr_seen = 1'b0;
      rws_far_model_i.press(4);
      repeat (6) @(posedge CLK);
      `CHK("cause", 3'b010, CAUSE)
      `CHK("held", 1'b1, cr_seen)
      GLOBAL_INT_EN <= 1'b1;
      arm_and_sleep();
      `CHK("branch", 1'b1, vb_seen)
      `CHK("vector", 12'h006, VECTOR_ADDR)
      pulse(3'b100);
      pulse(3'b010);
      `CHK("asleep", 1'b1, SLEEPING)
      rws_far_model_i.press(4);
      repeat (6) @(posedge CLK);
      `CHK("cause", 3'b010, CAUSE)
      `CHK("asleep", 1'b0, SLEEPING)
      WATCHDOG_ENABLE <= 1'b0;
      cr_seen = 1'b0;
      rws_far_model_i.fire_wdt();
      repeat (4) @(posedge CLK);
      `CHK("held", 1'b0, cr_seen)
      wrap_up();
   end
endmodule : tb_reset_wake_status
